// file: common/cbs_map.svh
// constants of the codec boot sequencer: message fields, timing and counts
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH
// ==========================================================
// clock and timing
`define CBS_CLK_HZ 10000000
`define CBS_BOOT_WAIT_MS 265
`define CBS_GAP_US 25
`define CBS_DEBOUNCE_MS 3
`define CBS_SCLK_HALF 8'h23
// ==========================================================
// message format
`define CBS_MSG_BITS 5'h18
`define CBS_DATA_FIRST_BIT 5'h10
`define CBS_NUM_SEL 2
`define CBS_SEL_ALL 2'h3
`define CBS_CHIP_WRITE 8'h08
`define CBS_CHIP_READ 8'h09
`define CBS_RW_BIT 5'h10
// ==========================================================
// codec register addresses and boot values (only non-zero settings)
`define CBS_REG_PLL0 8'h00
`define CBS_REG_DAC0 8'h02
`define CBS_REG_DAC1 8'h03
`define CBS_REG_MUTES 8'h05
`define CBS_REG_ADC0 8'h0E
`define CBS_REG_ADC1 8'h0F
`define CBS_REG_ADC2 8'h10
`define CBS_VAL_DAC0 8'h40
`define CBS_VAL_DAC1 8'h04
`define CBS_VAL_ADC0 8'h02
`define CBS_VAL_ADC1 8'h20
`define CBS_VAL_ADC2 8'h68
`define CBS_VAL_PLL0 8'h80
`define CBS_VAL_MUTE 8'hFF
`define CBS_VAL_UNMUTE 8'h00
`define CBS_PAD_BYTE 8'h00
`define CBS_LAST_MSG 3'h5
`endif

// file: common/cbs_pkg.sv
// types of the codec boot sequencer
package cbs_pkg;
  `include "cbs_map.svh"

  // ==========================================================
  // shifter
  typedef enum logic [2:0] {SH_IDLE, SH_LEAD, SH_LOW, SH_HIGH, SH_TRAIL} cbs_sh_st_t;

  typedef struct packed {
    cbs_sh_st_t st;
    logic [7:0] cnt;
    logic [4:0] bit_idx;
    logic [23:0] shreg;
    logic rd_cmd;
    logic [7:0] rx;
    logic sclk;
    logic mosi;
    logic [`CBS_NUM_SEL-1:0] sel_n;
    logic done;
    logic [7:0] rdata;
  } cbs_sh_state_t;

  // ==========================================================
  // sequencer
  typedef enum logic [3:0] {
    TS_BOOT, TS_CFG, TS_CFG_BUSY, TS_GAP, TS_IDLE,
    TS_MUTE_BUSY, TS_MUTED, TS_UNMUTE_BUSY
  } cbs_top_st_t;

  typedef struct packed {
    logic clear_s1;
    logic clear_s2;
    logic mute_s1;
    logic mute_s2;
    logic miso_s1;
    logic miso_s2;
    logic mute_stable;
    logic [15:0] deb_cnt;
    cbs_top_st_t st;
    logic [23:0] wcnt;
    logic [2:0] idx;
    logic start;
    logic [31:0] word;
    logic cfg_done;
  } cbs_top_state_t;
endpackage : cbs_pkg

// file: common/cbs_spi_if.sv
// link between the sequencer and its serial shifter
`timescale 1ns/1ps
`include "cbs_map.svh"
interface cbs_spi_if;
  logic clr;
  logic start;
  logic [23:0] word;
  logic [`CBS_NUM_SEL-1:0] mask;
  logic miso;
  logic done;
  logic [7:0] rdata;
  logic sclk;
  logic mosi;
  logic [`CBS_NUM_SEL-1:0] sel_n;
  modport seq (output clr, start, word, mask, miso, input done, rdata, sclk, mosi, sel_n);
  modport shf (input clr, start, word, mask, miso, output done, rdata, sclk, mosi, sel_n);
endinterface : cbs_spi_if

// file: hw/cbs_spi_shift.sv
// 24-bit serial shifter: clock idles high, msb first, one frame per message
`timescale 1ns/1ps
`include "cbs_map.svh"
module cbs_spi_shift
  import cbs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  cbs_spi_if.shf sp
);
  cbs_sh_state_t q;
  cbs_sh_state_t d;
  localparam cbs_sh_state_t SH_RESET = '{st: SH_IDLE, cnt: 8'h00, bit_idx: 5'h00, shreg: 24'h00_0000,
    rd_cmd: 1'b0, rx: 8'h00, sclk: 1'b1, mosi: 1'b0, sel_n: {`CBS_NUM_SEL{1'b1}}, done: 1'b0, rdata: 8'h00};

  // ==========================================================
  // frame sequencing
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.cnt = q.cnt + 8'h01;
    case (q.st)
      SH_IDLE: begin
        d.cnt = 8'h00;
        d.sclk = 1'b1;
        if (sp.start) begin
          d.shreg = sp.word;
          d.rd_cmd = sp.word[`CBS_RW_BIT];
          d.sel_n = ~sp.mask;
          d.bit_idx = 5'h00;
          d.st = SH_LEAD;
        end
      end
      SH_LEAD: begin
        if (q.cnt == `CBS_SCLK_HALF - 8'h01) begin
          d.cnt = 8'h00;
          d.st = SH_LOW;
        end
      end
      SH_LOW: begin
        // falling clock, next bit presented msb first
        d.sclk = 1'b0;
        d.mosi = q.shreg[23];
        if (q.cnt == `CBS_SCLK_HALF - 8'h01) begin
          d.cnt = 8'h00;
          d.sclk = 1'b1;
          d.st = SH_HIGH;
        end
      end
      SH_HIGH: begin
        if (q.cnt == `CBS_SCLK_HALF - 8'h01) begin
          d.cnt = 8'h00;
          d.shreg = {q.shreg[22:0], 1'b0};
          // sample the codec output late in the high phase
          if (q.rd_cmd && q.bit_idx >= `CBS_DATA_FIRST_BIT) begin
            d.rx = {q.rx[6:0], sp.miso};
          end
          d.bit_idx = q.bit_idx + 5'h01;
          // select held low through all 24 bits
          if (q.bit_idx == `CBS_MSG_BITS - 5'h01) begin
            d.st = SH_TRAIL;
          end else begin
            d.st = SH_LOW;
          end
        end
      end
      SH_TRAIL: begin
        if (q.cnt == `CBS_SCLK_HALF - 8'h01) begin
          d.sel_n = {`CBS_NUM_SEL{1'b1}};
          d.done = 1'b1;
          if (q.rd_cmd) begin
            d.rdata = q.rx;
          end
          d.st = SH_IDLE;
        end
      end
      default: begin
        d = SH_RESET;
      end
    endcase
    if (sp.clr) begin
      d = SH_RESET;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= SH_RESET;
    end else begin
      q <= d;
    end
  end

  assign sp.sclk = q.sclk;
  assign sp.mosi = q.mosi;
  assign sp.sel_n = q.sel_n;
  assign sp.done = q.done;
  assign sp.rdata = q.rdata;
endmodule : cbs_spi_shift

// file: hw/cbs_boot_top.sv
// codec boot sequencer: power-up wait, configuration writes, mute and unmute
// Operation
// - block is serial master: drives clock and data; codec output sampled only on read commands, which the sequencer never sends
// - select line held high from reset, before any sequencing
// - wait 265 ms after start-up before the first message
// - each transaction is exactly 24 bits inside one select assertion
// - messages held as 32-bit words; padding byte never shifted
// - only registers with non-zero settings are written at boot
// - chip address field identical for every family member
// - write-only, so several codecs may share one select
// - one select output per codec, both asserted together to frame every message
// - select is active low; codec accepts only while low
// - mute input ignored until configuration is finished
// - mute low sends one all-DAC mute message, then wait for high
// - mute high sends one unmute message, then back to idle
// - master clear low holds reset; release restarts boot from start
// - on a read command the returned data byte is captured
// - first byte is chip address shifted left, r/w in bit zero
// - mute writes 0xFF to DAC mute register, unmute writes zero
// - serial clock idles high between transactions
// - select stays low for all 24 bits; one frame per message
`timescale 1ns/1ps
`include "cbs_map.svh"

module cbs_boot_top
  import cbs_pkg::*;
#(
  parameter int BOOT_WAIT_CYCLES = (`CBS_CLK_HZ / 1000) * `CBS_BOOT_WAIT_MS,
  parameter int DEBOUNCE_CYCLES = (`CBS_CLK_HZ / 1000) * `CBS_DEBOUNCE_MS
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic master_clear_n_in,
  input wire logic mute_n_in,
  input wire logic control_serial_in_in,
  output logic control_serial_clock_out,
  output logic control_serial_out_out,
  output logic [`CBS_NUM_SEL-1:0] control_select_n_out,
  output logic config_done_out,
  output logic [7:0] read_data_out
);
  // terminal counts of the wait, gap and debounce timers
  localparam int GAP_CYCLES = (`CBS_CLK_HZ / 1000000) * `CBS_GAP_US;
  localparam logic [23:0] BOOT_LAST = 24'(BOOT_WAIT_CYCLES - 1);
  localparam logic [23:0] GAP_LAST = 24'(GAP_CYCLES - 1);
  localparam logic [15:0] DEB_LAST = 16'(DEBOUNCE_CYCLES - 1);
  localparam cbs_top_state_t TOP_RESET = '{
    clear_s1: 1'b0,
    clear_s2: 1'b0,
    mute_s1: 1'b1,
    mute_s2: 1'b1,
    miso_s1: 1'b0,
    miso_s2: 1'b0,
    mute_stable: 1'b1,
    deb_cnt: 16'h0000,
    st: TS_BOOT,
    wcnt: 24'h00_0000,
    idx: 3'h0,
    start: 1'b0,
    word: 32'h0000_0000,
    cfg_done: 1'b0
  };

  // sequencer state and its next value
  cbs_top_state_t q;
  cbs_top_state_t d;
  cbs_spi_if sp ();

  // ==========================================================
  // message builder: pad, chip write address, register, data
  function automatic logic [31:0] build_msg(input logic [7:0] reg_addr, input logic [7:0] val);
    build_msg = {`CBS_PAD_BYTE, `CBS_CHIP_WRITE, reg_addr, val};
  endfunction : build_msg

  // boot table, non-zero settings only
  function automatic logic [31:0] boot_msg(input logic [2:0] idx);
    case (idx)
      3'h0: boot_msg = build_msg(`CBS_REG_DAC0, `CBS_VAL_DAC0);
      3'h1: boot_msg = build_msg(`CBS_REG_DAC1, `CBS_VAL_DAC1);
      3'h2: boot_msg = build_msg(`CBS_REG_ADC0, `CBS_VAL_ADC0);
      3'h3: boot_msg = build_msg(`CBS_REG_ADC1, `CBS_VAL_ADC1);
      3'h4: boot_msg = build_msg(`CBS_REG_ADC2, `CBS_VAL_ADC2);
      default: boot_msg = build_msg(`CBS_REG_PLL0, `CBS_VAL_PLL0);
    endcase
  endfunction : boot_msg

  // ==========================================================
  // sequencer next state
  always_comb begin
    d = q;
    d.start = 1'b0;
    // two-stage synchronisers for pin inputs
    d.clear_s1 = master_clear_n_in;
    d.clear_s2 = q.clear_s1;
    d.mute_s1 = mute_n_in;
    d.mute_s2 = q.mute_s1;
    d.miso_s1 = control_serial_in_in;
    d.miso_s2 = q.miso_s1;
    // debounce: level must hold for the whole window
    if (q.mute_s2 != q.mute_stable) begin
      if (q.deb_cnt == DEB_LAST) begin
        d.mute_stable = q.mute_s2;
        d.deb_cnt = 16'h0000;
      end else begin
        d.deb_cnt = q.deb_cnt + 16'h0001;
      end
    end else begin
      d.deb_cnt = 16'h0000;
    end
    // boot, configuration and mute sequencing
    case (q.st)
      TS_BOOT: begin
        // power-up wait before the first message
        if (q.wcnt == BOOT_LAST) begin
          d.wcnt = 24'h00_0000;
          d.idx = 3'h0;
          d.st = TS_CFG;
        end else begin
          d.wcnt = q.wcnt + 24'h00_0001;
        end
      end
      TS_CFG: begin
        // launch the next boot message
        d.start = 1'b1;
        d.word = boot_msg(q.idx);
        d.st = TS_CFG_BUSY;
      end
      TS_CFG_BUSY: begin
        if (sp.done) begin
          if (q.idx == `CBS_LAST_MSG) begin
            d.cfg_done = 1'b1;
            d.st = TS_IDLE;
          end else begin
            d.idx = q.idx + 3'h1;
            d.wcnt = 24'h00_0000;
            d.st = TS_GAP;
          end
        end
      end
      TS_GAP: begin
        // spacing between configuration frames
        if (q.wcnt == GAP_LAST) begin
          d.st = TS_CFG;
        end else begin
          d.wcnt = q.wcnt + 24'h00_0001;
        end
      end
      TS_IDLE: begin
        // mute only reachable once configuration is done
        if (!q.mute_stable) begin
          d.start = 1'b1;
          d.word = build_msg(`CBS_REG_MUTES, `CBS_VAL_MUTE);
          d.st = TS_MUTE_BUSY;
        end
      end
      TS_MUTE_BUSY: begin
        if (sp.done) begin
          d.st = TS_MUTED;
        end
      end
      TS_MUTED: begin
        // unmute once the debounced input is back high
        if (q.mute_stable) begin
          d.start = 1'b1;
          d.word = build_msg(`CBS_REG_MUTES, `CBS_VAL_UNMUTE);
          d.st = TS_UNMUTE_BUSY;
        end
      end
      TS_UNMUTE_BUSY: begin
        if (sp.done) begin
          d.st = TS_IDLE;
        end
      end
      default: begin
        d.st = TS_BOOT;
      end
    endcase
    // master clear holds the sequence at its first step
    if (!q.clear_s2) begin
      d = TOP_RESET;
      d.clear_s1 = master_clear_n_in;
      d.clear_s2 = q.clear_s1;
      d.mute_s1 = mute_n_in;
      d.mute_s2 = q.mute_s1;
      d.miso_s1 = control_serial_in_in;
      d.miso_s2 = q.miso_s1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= TOP_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // shifter link
  assign sp.clr = ~q.clear_s2;
  assign sp.start = q.start;
  assign sp.word = q.word[23:0];
  assign sp.mask = `CBS_SEL_ALL;
  assign sp.miso = q.miso_s2;

  cbs_spi_shift u_shift (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sp(sp)
  );

  // pins straight from shifter flops, done from the sequencer flop; select high from reset
  assign control_serial_clock_out = sp.sclk;
  assign control_serial_out_out = sp.mosi;
  assign control_select_n_out = sp.sel_n;
  assign config_done_out = q.cfg_done;
  assign read_data_out = sp.rdata;
endmodule : cbs_boot_top

// file: dv/cbs_boot_props.sv
// port checker for the codec boot sequencer
`timescale 1ns/1ps
`include "cbs_map.svh"
module cbs_boot_props
  import cbs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic master_clear_n_in,
  input wire logic control_serial_clock_out,
  input wire logic control_serial_out_out,
  input wire logic [`CBS_NUM_SEL-1:0] control_select_n_out,
  input wire logic config_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire sel_n = control_select_n_out[0];
  wire sck = control_serial_clock_out;
  logic [11:0] len_q;
  logic [5:0] falls_q;
  logic sck_q;
  // ==========================================================
  // frame length and clock falls, cleared while deselected
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      len_q <= '0;
      falls_q <= '0;
      sck_q <= 1'b1;
    end else if (sel_n) begin
      len_q <= '0;
      falls_q <= '0;
      sck_q <= sck;
    end else begin
      len_q <= len_q + 12'h001;
      falls_q <= falls_q + {5'h00, sck_q & ~sck};
      sck_q <= sck;
    end
  end
  // ==========================================================
  // properties
  property p_idle_high; sel_n |-> sck; endproperty
  property p_sel_pair; control_select_n_out[0] == control_select_n_out[1]; endproperty
  property p_lead; $fell(sel_n) |-> sck [*8]; endproperty
  property p_low; $fell(sck) |-> !sck [*8]; endproperty
  property p_bits; $rose(sel_n) && master_clear_n_in |-> falls_q == 6'h18; endproperty
  property p_len; $rose(sel_n) && master_clear_n_in |-> len_q inside {[12'd1749:12'd1751]}; endproperty
  property p_clear; !master_clear_n_in [*4] |-> sel_n && sck && !config_done_out; endproperty
  property p_done_hold; config_done_out && master_clear_n_in |=> config_done_out; endproperty
  property p_mosi; $changed(control_serial_out_out) && !sel_n && !$past(sel_n) |-> $fell(sck); endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock not high while deselected");
  a_sel_pair: assert property (p_sel_pair) else $error("selects differ");
  a_lead: assert property (p_lead) else $error("clock fell too soon after select");
  a_low: assert property (p_low) else $error("clock low phase too short");
  a_bits: assert property (p_bits) else $error("frame not 24 clocks");
  a_len: assert property (p_len) else $error("frame length wrong");
  a_clear: assert property (p_clear) else $error("outputs active in master clear");
  a_done_hold: assert property (p_done_hold) else $error("config done dropped");
  a_mosi: assert property (p_mosi) else $error("data moved off falling clock");
  c_done: cover property ($rose(config_done_out));
  c_post: cover property ($fell(sel_n) && config_done_out);
  c_abort: cover property (!master_clear_n_in && !sel_n);
endmodule : cbs_boot_props

// file: dv/cbs_codec_model.sv
// behavioural codec control port: takes whole 24-bit frames
`timescale 1ns/1ps
module cbs_codec_model (
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic [23:0] word_out,
  output logic [15:0] frames_out
);
  logic [23:0] sh_q = '0;
  logic [23:0] word_q = '0;
  logic [15:0] frames_q = '0;
  logic miso_q = 1'b0;
  int bits = 0;
  // rising clock shifts msb first while selected; release keeps whole frames only
  always @(posedge sclk_in or posedge sel_n_in) begin
    if (sel_n_in !== 1'b0) begin
      if (bits == 24) begin
        word_q <= sh_q;
        frames_q <= frames_q + 16'h0001;
      end
      bits <= 0;
    end else begin
      sh_q <= {sh_q[22:0], mosi_in};
      bits <= bits + 1;
    end
  end
  // answer on falling clock, toggle when released
  always @(negedge sclk_in or posedge sel_n_in) begin
    miso_q <= sel_n_in ? ~miso_q : sh_q[23];
  end
  assign miso_out = miso_q;
  assign word_out = word_q;
  assign frames_out = frames_q;
endmodule : cbs_codec_model

// file: dv/cbs_boot_top_bench.sv
// self-checking bench for the codec boot sequencer
`timescale 1ns/1ps
module cbs_boot_top_bench;
  localparam int BOOT = 200;
  logic clk_in = 1'b0;
  logic reset_n = 1'b0;
  logic clear_n = 1'b1;
  logic mute_n = 1'b1;
  logic sck, mosi, miso, done;
  logic [1:0] sel_n;
  logic [7:0] rdata;
  logic [23:0] word;
  logic [15:0] frames;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [23:0] tbl [6] = '{24'h08_0240, 24'h08_0304, 24'h08_0E02, 24'h08_0F20, 24'h08_1068, 24'h08_0080};
  cbs_boot_top #(.BOOT_WAIT_CYCLES(BOOT), .DEBOUNCE_CYCLES(20)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n),
    .master_clear_n_in(clear_n), .mute_n_in(mute_n), .control_serial_in_in(miso),
    .control_serial_clock_out(sck), .control_serial_out_out(mosi), .control_select_n_out(sel_n),
    .config_done_out(done), .read_data_out(rdata));
  cbs_codec_model i_codec (.sclk_in(sck), .sel_n_in(sel_n[0]), .mosi_in(mosi), .miso_out(miso),
    .word_out(word), .frames_out(frames));
  // ==========================================================
  // clock and cycle ceiling
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : check
  task automatic conclude();
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // wait for the next whole frame and compare it
  task automatic next_frame(input logic [23:0] exp);
    logic [15:0] n;
    int k;
    n = frames;
    k = 0;
    while (frames == n && k < 4000) begin
      @(negedge clk_in);
      k++;
    end
    check("frame wait", k < 4000, 1'b1);
    check("frame", word, exp);
  endtask : next_frame
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("sel", sel_n, 2'h3);
    check("sclk", sck, 1'b1);
    check("done", done, 1'b0);
    check("rdata", rdata, 8'h00);
  endtask : t_reset
  // boot wait, six writes, mute pulse during boot ignored
  task automatic t_boot();
    int k;
    logic [15:0] n;
    k = 0;
    while (sel_n == 2'h3 && k < 5000) begin
      @(negedge clk_in);
      k++;
    end
    check("boot wait", k >= BOOT, 1'b1);
    check("boot wait max", k < BOOT + 10, 1'b1);
    for (int i = 0; i < 6; i++) begin
      if (i == 1) begin
        mute_n = 1'b0;
        repeat (40) @(negedge clk_in);
        mute_n = 1'b1;
      end
      next_frame(tbl[i]);
    end
    repeat (20) @(negedge clk_in);
    check("done", done, 1'b1);
    n = frames;
    repeat (2500) @(negedge clk_in);
    check("frames", frames, n);
  endtask : t_boot
  task automatic t_mute();
    mute_n = 1'b0;
    next_frame(24'h08_05FF);
    mute_n = 1'b1;
    next_frame(24'h08_0500);
  endtask : t_mute
  // master clear in mid-frame restarts from step 0
  task automatic t_clear();
    int k;
    k = 0;
    mute_n = 1'b0;
    while (sel_n == 2'h3 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    repeat (300) @(negedge clk_in);
    clear_n = 1'b0;
    repeat (6) @(negedge clk_in);
    check("sel", sel_n, 2'h3);
    check("done", done, 1'b0);
    mute_n = 1'b1;
    clear_n = 1'b1;
    t_boot();
  endtask : t_clear
  initial begin
    repeat (16) @(negedge clk_in);
    reset_n = 1'b1;
    t_reset();
    t_boot();
    t_mute();
    t_clear();
    conclude();
  end
endmodule : cbs_boot_top_bench
bind cbs_boot_top cbs_boot_props i_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .master_clear_n_in(master_clear_n_in), .control_serial_clock_out(control_serial_clock_out),
  .control_serial_out_out(control_serial_out_out), .control_select_n_out(control_select_n_out),
  .config_done_out(config_done_out));
